// >>> core/sdrc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module sdrc_fifo #(
   parameter int W = 9,
   parameter int D = 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   output logic [$clog2(D):0] count
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0] wp;
   logic [AW:0] rp;

   assign count = wp - rp;
   assign in_ready = count != (AW+1)'(D);
   assign out_valid = count != '0;
   assign out_data = mem[rp[AW-1:0]];

   always_ff @(posedge clk_sys) begin
      if (in_valid && in_ready) begin
         mem[wp[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wp <= '0;
      end else if (in_valid && in_ready) begin
         wp <= wp + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rp <= '0;
      end else if (out_valid && out_ready) begin
         rp <= rp + 1'b1;
      end
   end
endmodule

module sdrc_ctrl (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic otf_en,
   input wire logic mrs_chop,
   input wire logic hot_temp,
   input wire logic vref_floated,
   input wire logic req_valid,
   output logic req_ready,
   input wire sdrc_pkg::sdrc_req_s req,
   input wire logic wd_valid,
   output logic wd_ready,
   input wire sdrc_pkg::sdrc_wdat_s wd,
   output logic rd_valid,
   output logic [sdrc_pkg::DQ_W-1:0] rd_data,
   output var sdrc_pkg::sdrc_pins_s pins,
   output logic dm,
   output logic [sdrc_pkg::DQ_W-1:0] dq_out,
   output logic dq_oe,
   input wire logic [sdrc_pkg::DQ_W-1:0] dq_in,
   output logic dqs_out,
   output logic dqs_oe,
   input wire logic dqs_in
);
   sdrc_pkg::sdrc_st_e st;
   sdrc_pkg::sdrc_wdat_s f_data;
   logic [$bits(sdrc_pkg::sdrc_wdat_s)-1:0] f_raw;
   logic f_valid;
   logic [3:0] f_cnt;
   logic [sdrc_pkg::NBANK-1:0] bank_open;
   logic [15:0] open_row [sdrc_pkg::NBANK];
   logic [7:0] wait_cnt;
   logic [7:0] act_wait;
   logic [10:0] ref_tmr;
   logic [3:0] owed;
   logic [9:0] vref_hold;
   logic [4:0] cyc;
   logic [4:0] burst_end;
   logic [3:0] nbeats;
   logic [3:0] beats;
   logic is_wr;
   logic auto_cl;
   logic ref_due;
   logic ref_tick;
   logic do_act;
   logic do_pre;
   logic pre_all;
   logic do_ref;
   logic do_rw;
   logic do_sre;
   logic do_srx;
   logic wr_beat;
   logic rd_beat;
   logic [sdrc_pkg::DQ_W-1:0] dq_s1;
   logic [sdrc_pkg::DQ_W-1:0] dq_s2;
   logic dqs_s1;
   logic dqs_s2;
   logic [3:0] next_cmd;
   logic [2:0] next_ba;
   logic [15:0] next_addr;
   logic next_cke;

   // Write data staging
   sdrc_fifo #(
      .W($bits(sdrc_pkg::sdrc_wdat_s)),
      .D(sdrc_pkg::FIFO_DEPTH)
   ) u_wfifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .in_valid(wd_valid),
      .in_ready(wd_ready),
      .in_data(wd),
      .out_valid(f_valid),
      .out_ready(wr_beat),
      .out_data(f_raw),
      .count(f_cnt)
   );
   assign f_data = f_raw;

   // Burst length from A12 or from the fixed mode setting
   assign beats = (otf_en ? req.chop : mrs_chop) ? sdrc_pkg::BEATS_CHOP :
                  sdrc_pkg::BEATS_FULL;
   assign burst_end = (is_wr ? sdrc_pkg::WR_LAT : sdrc_pkg::RD_LAT + sdrc_pkg::SYNC_LAT)
                      + {1'b0, nbeats};
   assign ref_due = owed == sdrc_pkg::POST_MAX || (owed != 4'h0 && !req_valid);
   assign ref_tick = ref_tmr == 11'h000;

   // Command selection, one command per cycle at most
   always_comb begin
      do_act = 1'b0;
      do_pre = 1'b0;
      pre_all = 1'b0;
      do_ref = 1'b0;
      do_rw = 1'b0;
      do_sre = 1'b0;
      do_srx = 1'b0;
      req_ready = 1'b0;
      case (st)
         sdrc_pkg::ST_IDLE: begin
            if (wait_cnt == 8'h00) begin
               if (ref_due) begin
                  if (|bank_open) begin
                     do_pre = 1'b1;
                     pre_all = 1'b1;
                  end else begin
                     do_ref = 1'b1;
                  end
               end else if (req_valid) begin
                  case (req.op)
                     sdrc_pkg::OP_READ, sdrc_pkg::OP_WRITE: begin
                        if (!bank_open[req.bank]) begin
                           do_act = act_wait == 8'h00;
                        end else if (open_row[req.bank] != req.row) begin
                           do_pre = 1'b1;
                        end else begin
                           // Another bank may still be auto closing here
                           do_rw = req.op == sdrc_pkg::OP_READ ||
                                   ({1'b0, f_cnt} >= {1'b0, beats} &&
                                    vref_hold == 10'h000);
                           req_ready = do_rw;
                        end
                     end
                     sdrc_pkg::OP_PRE: begin
                        do_pre = 1'b1;
                        pre_all = req.all_banks;
                        req_ready = 1'b1;
                     end
                     sdrc_pkg::OP_SREF: begin
                        if (|bank_open) begin
                           do_pre = 1'b1;
                           pre_all = 1'b1;
                        end else begin
                           do_sre = 1'b1;
                           req_ready = 1'b1;
                        end
                     end
                     default: begin
                     end
                  endcase
               end
            end
         end
         sdrc_pkg::ST_SREF: begin
            do_srx = req_valid;
         end
         default: begin
         end
      endcase
   end

   // Pin values for the selected command
   always_comb begin
      next_cmd = sdrc_pkg::CMD_NOP;
      next_ba = pins.ba;
      next_addr = pins.addr;
      next_cke = pins.cke;
      if (do_act) begin
         next_cmd = sdrc_pkg::CMD_ACT;
         next_ba = req.bank;
         next_addr = req.row;
      end
      if (do_pre) begin
         next_cmd = sdrc_pkg::CMD_PRE;
         next_ba = req.bank;
         next_addr = 16'h0000;
         next_addr[sdrc_pkg::ADDR_AP] = pre_all;
      end
      if (do_ref || do_sre) begin
         next_cmd = sdrc_pkg::CMD_REF;
         next_cke = !do_sre;
      end
      if (do_rw) begin
         next_cmd = (req.op == sdrc_pkg::OP_READ) ? sdrc_pkg::CMD_RD :
                    sdrc_pkg::CMD_WR;
         next_ba = req.bank;
         next_addr = {6'h00, req.col};
         next_addr[sdrc_pkg::ADDR_AP] = req.auto_close;
         next_addr[sdrc_pkg::ADDR_BC] = !(otf_en && req.chop);
      end
      if (do_srx) begin
         next_cke = 1'b1;
      end
   end

   // Pins change on the rising edge the device samples
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pins <= '{cke: 1'b1, cmd: sdrc_pkg::CMD_NOP, ba: 3'h0, addr: 16'h0000};
      end else begin
         pins <= '{cke: next_cke, cmd: next_cmd, ba: next_ba, addr: next_addr};
      end
   end

   // Sequencer
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st <= sdrc_pkg::ST_IDLE;
         cyc <= 5'h00;
         is_wr <= 1'b0;
         nbeats <= 4'h0;
         auto_cl <= 1'b0;
      end else begin
         case (st)
            sdrc_pkg::ST_IDLE: begin
               if (do_rw) begin
                  st <= sdrc_pkg::ST_BURST;
                  cyc <= 5'h00;
                  is_wr <= req.op == sdrc_pkg::OP_WRITE;
                  nbeats <= beats;
                  auto_cl <= req.auto_close;
               end else if (do_sre) begin
                  st <= sdrc_pkg::ST_SREF;
               end
            end
            sdrc_pkg::ST_BURST: begin
               if (cyc == burst_end) begin
                  st <= sdrc_pkg::ST_IDLE;
               end else begin
                  cyc <= cyc + 5'h01;
               end
            end
            sdrc_pkg::ST_SREF: begin
               if (do_srx) begin
                  st <= sdrc_pkg::ST_IDLE;
               end
            end
            default: begin
               st <= sdrc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Command spacing timer
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wait_cnt <= 8'h00;
      end else if (do_act) begin
         wait_cnt <= sdrc_pkg::RCD_CYC;
      end else if (do_pre) begin
         wait_cnt <= sdrc_pkg::RP_CYC;
      end else if (do_ref) begin
         wait_cnt <= sdrc_pkg::RFC_CYC;
      end else if (do_srx) begin
         wait_cnt <= sdrc_pkg::XS_CYC;
      end else if (wait_cnt != 8'h00) begin
         wait_cnt <= wait_cnt - 8'h01;
      end
   end

   // Activate hold-off after an auto precharge
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         act_wait <= 8'h00;
      end else if (st == sdrc_pkg::ST_BURST && cyc == burst_end && auto_cl) begin
         act_wait <= sdrc_pkg::RP_CYC;
      end else if (act_wait != 8'h00) begin
         act_wait <= act_wait - 8'h01;
      end
   end

   // Open row tracking per bank
   for (genvar b = 0; b < sdrc_pkg::NBANK; b++) begin : g_bank
      logic open;
      logic [15:0] row;
      logic hit;
      assign hit = req.bank == 3'(b);
      assign bank_open[b] = open;
      assign open_row[b] = row;
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            open <= 1'b0;
            row <= 16'h0000;
         end else if (do_act && hit) begin
            open <= 1'b1;
            row <= req.row;
         end else if ((do_pre && (pre_all || hit)) ||
                      (do_rw && req.auto_close && hit)) begin
            open <= 1'b0;
         end
      end
   end

   // Refresh credit, frozen while the device refreshes itself
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ref_tmr <= sdrc_pkg::REFI_CYC;
         owed <= 4'h0;
      end else if (st != sdrc_pkg::ST_SREF) begin
         // Reload one short so the tick period equals the interval
         ref_tmr <= ref_tick ? (hot_temp ? sdrc_pkg::REFI_HOT_CYC : sdrc_pkg::REFI_CYC) -
                    11'h001 : ref_tmr - 11'h001;
         // A new credit and a refresh taken in the same cycle both count, even at the cap
         owed <= owed + {3'h0, ref_tick && (owed != sdrc_pkg::POST_MAX || do_ref)}
                 - {3'h0, do_ref};
      end
   end

   // Write hold-off after self refresh with floated reference
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         vref_hold <= 10'h000;
      end else if (do_srx && vref_floated) begin
         vref_hold <= sdrc_pkg::VREF_WR_CLK;
      end else if (vref_hold != 10'h000) begin
         vref_hold <= vref_hold - 10'h001;
      end
   end

   assign wr_beat = st == sdrc_pkg::ST_BURST && is_wr && f_valid &&
                    cyc >= sdrc_pkg::WR_LAT - 5'h01 &&
                    cyc < sdrc_pkg::WR_LAT - 5'h01 + {1'b0, nbeats};
   assign rd_beat = st == sdrc_pkg::ST_BURST && !is_wr &&
                    cyc >= sdrc_pkg::RD_LAT + sdrc_pkg::SYNC_LAT &&
                    cyc < burst_end;

   // Write data, mask and strobe
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dq_out <= '0;
         dm <= 1'b0;
         dq_oe <= 1'b0;
         dqs_oe <= 1'b0;
         dqs_out <= 1'b0;
      end else begin
         dq_oe <= wr_beat;
         dqs_oe <= wr_beat;
         dqs_out <= wr_beat && cyc[0];
         if (wr_beat) begin
            dq_out <= f_data.data;
            dm <= f_data.mask;
         end
      end
   end

   // Read data synchroniser and capture
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dq_s1 <= '0;
         dq_s2 <= '0;
         dqs_s1 <= 1'b0;
         dqs_s2 <= 1'b0;
      end else begin
         dq_s1 <= dq_in;
         dq_s2 <= dq_s1;
         dqs_s1 <= dqs_in;
         dqs_s2 <= dqs_s1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rd_valid <= 1'b0;
         rd_data <= '0;
      end else begin
         rd_valid <= rd_beat;
         if (rd_beat) begin
            rd_data <= dq_s2;
         end
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence s_rw_cmd;
      pins.cmd == sdrc_pkg::CMD_RD || pins.cmd == sdrc_pkg::CMD_WR;
   endsequence
   sequence s_quiet8;
      (pins.cmd == sdrc_pkg::CMD_NOP)[*8];
   endsequence
   sequence s_wr_full;
      pins.cmd == sdrc_pkg::CMD_WR && nbeats == sdrc_pkg::BEATS_FULL;
   endsequence
   sequence s_wr_chop;
      pins.cmd == sdrc_pkg::CMD_WR && nbeats == sdrc_pkg::BEATS_CHOP;
   endsequence

   a_burst_quiet: assert property (s_rw_cmd |=> (pins.cmd == sdrc_pkg::CMD_NOP)[*7])
      else $error("Command issued inside a burst");
   a_ref_quiet: assert property ((pins.cmd == sdrc_pkg::CMD_REF && pins.cke) |=> s_quiet8)
      else $error("Command issued during refresh");
   a_cke_high: assert property ((pins.cmd == sdrc_pkg::CMD_PRE ||
                                 pins.cmd == sdrc_pkg::CMD_ACT) |-> pins.cke)
      else $error("Clock enable low on precharge or activate");
   a_pre_act_gap: assert property ((pins.cmd == sdrc_pkg::CMD_PRE) |=>
                                   (pins.cmd != sdrc_pkg::CMD_ACT)[*2])
      else $error("Activate too soon after precharge");
   a_act_first: assert property (do_rw |-> bank_open[req.bank])
      else $error("Access to a closed bank");
   a_wr_full: assert property (s_wr_full |-> ##5 dq_oe[*8] ##1 !dq_oe)
      else $error("Full write burst beat count wrong");
   a_wr_chop: assert property (s_wr_chop |-> ##5 dq_oe[*4] ##1 !dq_oe)
      else $error("Chopped write burst beat count wrong");
   a_owed_cap: assert property (owed <= sdrc_pkg::POST_MAX)
      else $error("Too many refreshes postponed");
   a_ref_forced: assert property ((owed == sdrc_pkg::POST_MAX && st == sdrc_pkg::ST_IDLE &&
                                   wait_cnt == 8'h00) |-> (do_pre || do_ref))
      else $error("Overdue refresh not issued");
   a_vref_hold: assert property ((vref_hold != 10'h000) |->
                                 !(do_rw && req.op == sdrc_pkg::OP_WRITE))
      else $error("Write too soon after self refresh");
   a_sref_cke: assert property ((st == sdrc_pkg::ST_SREF) |-> !pins.cke)
      else $error("Clock enable high in self refresh");
   a_pre_all: assert property ((pins.cmd == sdrc_pkg::CMD_PRE && pins.addr[sdrc_pkg::ADDR_AP])
                               |-> bank_open == '0)
      else $error("Bank left open after precharge all");
endmodule

`default_nettype wire

// >>> core/sdrc_pkg.sv
package sdrc_pkg;
   localparam int CLK_MHZ = 200;
   localparam int T_REFI_NS = 7800;
   localparam int T_REFI_HOT_NS = 3900;
   localparam int T_RP_NS = 14;
   localparam int T_RCD_NS = 14;
   localparam int T_RFC_NS = 350;
   localparam int T_XS_NS = 360;
   // Longest intervals round down, least times round up
   localparam logic [10:0] REFI_CYC = 11'((T_REFI_NS * CLK_MHZ) / 1000);
   localparam logic [10:0] REFI_HOT_CYC = 11'((T_REFI_HOT_NS * CLK_MHZ) / 1000);
   localparam logic [7:0] RP_CYC = 8'((T_RP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] RCD_CYC = 8'((T_RCD_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] RFC_CYC = 8'((T_RFC_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] XS_CYC = 8'((T_XS_NS * CLK_MHZ + 999) / 1000);
   localparam logic [9:0] VREF_WR_CLK = 10'h200;
   localparam logic [4:0] RD_LAT = 5'h06;
   localparam logic [4:0] WR_LAT = 5'h05;
   localparam logic [4:0] SYNC_LAT = 5'h02;
   localparam logic [3:0] BEATS_CHOP = 4'h4;
   localparam logic [3:0] BEATS_FULL = 4'h8;
   localparam logic [3:0] POST_MAX = 4'h8;
   localparam int NBANK = 8;
   localparam int DQ_W = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int ADDR_AP = 10;
   localparam int ADDR_BC = 12;
   // Command pins {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_RD = 4'h5;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_REF = 4'h1;
   typedef enum logic [1:0] {
      OP_READ = 2'h0,
      OP_WRITE = 2'h1,
      OP_PRE = 2'h2,
      OP_SREF = 2'h3
   } sdrc_op_e;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_BURST = 2'h1,
      ST_SREF = 2'h3
   } sdrc_st_e;
   typedef struct packed {
      sdrc_op_e op;
      logic auto_close;
      logic chop;
      logic all_banks;
      logic [2:0] bank;
      logic [15:0] row;
      logic [9:0] col;
   } sdrc_req_s;
   typedef struct packed {
      logic [DQ_W-1:0] data;
      logic mask;
   } sdrc_wdat_s;
   typedef struct packed {
      logic cke;
      logic [3:0] cmd;
      logic [2:0] ba;
      logic [15:0] addr;
   } sdrc_pins_s;
endpackage

// >>> tb/sdram_rw_precharge_refresh_cmds_test.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_rw_precharge_refresh_cmds_test;
   logic clk_sys, rst_n, otf_en, mrs_chop, hot_temp, vref_floated, req_valid, req_ready;
   logic wd_valid, wd_ready, rd_valid, dm, dq_oe, dqs_out, dqs_oe, dqs_in, last_ch, last_ac;
   sdrc_pkg::sdrc_req_s req;
   sdrc_pkg::sdrc_wdat_s wd;
   sdrc_pkg::sdrc_pins_s pins;
   logic [7:0] rd_data, dq_out, dq_in;
   logic [7:0] exp_mem [0:8191];
   logic [7:0] q [$];
   logic [2:0] last_b;
   int errors, check_count, cyc, viol, refs, last_wait, r0;
   sdrc_ctrl uut (.clk_sys(clk_sys), .rst_n(rst_n), .otf_en(otf_en), .mrs_chop(mrs_chop),
      .hot_temp(hot_temp), .vref_floated(vref_floated), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .wd_valid(wd_valid), .wd_ready(wd_ready), .wd(wd),
      .rd_valid(rd_valid), .rd_data(rd_data), .pins(pins), .dm(dm), .dq_out(dq_out),
      .dq_oe(dq_oe), .dq_in(dq_in), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .dqs_in(dqs_in));
   sdrc_dram_model dev (.clk_sys(clk_sys), .otf_en(otf_en), .mrs_chop(mrs_chop), .pins(pins),
      .dm(dm), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .dqs_in(dqs_in), .viol(viol),
      .refs(refs));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      check_count++;
      if (seen !== want) begin
         errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   function automatic int nbeats(input logic ch);
      return otf_en ? (ch ? 4 : 8) : (mrs_chop ? 4 : 8);
   endfunction
   task automatic req_go(input sdrc_pkg::sdrc_op_e op, input logic ac, input logic ch,
         input logic all, input logic [2:0] b, input logic [15:0] r, input logic [9:0] c);
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req <= '{op, ac, ch, all, b, r, c};
      last_wait = 0;
      do begin
         @(negedge clk_sys);
         last_wait++;
      end while (req_ready !== 1'b1 && last_wait < 5000);
      last_b = b;
      last_ac = ac;
      last_ch = ch;
      @(posedge clk_sys);
      req_valid <= 1'b0;
   endtask
   task automatic push(input logic [7:0] d, input logic m);
      int n;
      n = 0;
      @(posedge clk_sys);
      wd_valid <= 1'b1;
      wd <= '{d, m};
      do @(negedge clk_sys); while (wd_ready !== 1'b1 && n++ < 5000);
      @(posedge clk_sys);
      wd_valid <= 1'b0;
   endtask
   task automatic wr_burst(input logic [2:0] b, input logic [15:0] r, input logic [9:0] c,
         input logic ac, input logic ch);
      logic [7:0] d;
      logic m;
      for (int k = 0; k < nbeats(ch); k++) begin
         d = 8'($urandom);
         m = ($urandom % 4) == 0;
         push(d, m);
         if (!m) exp_mem[{b, c + 10'(k)}] = d;
      end
      @(negedge clk_sys);
      if (nbeats(ch) == 8) check(16'(wd_ready), 16'h0000);
      req_go(sdrc_pkg::OP_WRITE, ac, ch, 1'b0, b, r, c);
   endtask
   task automatic rd_burst(input logic [2:0] b, input logic [15:0] r, input logic [9:0] c,
         input logic ac, input logic ch);
      for (int k = 0; k < nbeats(ch); k++) q.push_back(exp_mem[{b, c + 10'(k)}]);
      req_go(sdrc_pkg::OP_READ, ac, ch, 1'b0, b, r, c);
   endtask
   task automatic done_test(input string name);
      int n;
      n = 0;
      while (q.size() != 0 && n++ < 500) @(posedge clk_sys);
      repeat (20) @(posedge clk_sys);
      check(16'(q.size()), 16'h0000);
      check(16'(viol), 16'h0000);
      $display("test %s done", name);
   endtask
   always @(posedge clk_sys) begin
      if (rst_n && rd_valid === 1'b1) begin
         if (q.size() == 0) check(16'(rd_data), 16'hFFFF);
         else check(16'(rd_data), 16'(q.pop_front()));
      end
      if (rst_n) check(16'({dqs_oe, dqs_out && !dqs_oe}), 16'({dq_oe, 1'b0}));
      if (rst_n && (pins.cmd === sdrc_pkg::CMD_RD || pins.cmd === sdrc_pkg::CMD_WR)) begin
         check({pins.cke, pins.addr[12], pins.addr[10], pins.ba},
            {10'h0, 1'b1, !(otf_en && last_ch), last_ac, last_b});
      end
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 40000) begin
         errors++;
         conclude();
      end
   end
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      wd_valid = 1'b0;
      req = '0;
      wd = '0;
      otf_en = 1'b1;
      mrs_chop = 1'b0;
      hot_temp = 1'b0;
      vref_floated = 1'b0;
      for (int i = 0; i < 8192; i++) exp_mem[i] = 8'(i) ^ 8'h5A;
      void'($urandom(32'h53328C1B));
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      wr_burst(3'h2, 16'h0000, 10'h010, 1'b0, 1'b0);
      rd_burst(3'h2, 16'h0000, 10'h010, 1'b0, 1'b0);
      wr_burst(3'h2, 16'h0000, 10'h020, 1'b1, 1'b1);
      rd_burst(3'h2, 16'h0000, 10'h020, 1'b1, 1'b1);
      rd_burst(3'h5, 16'h0000, 10'h040, 1'b0, 1'b0);
      rd_burst(3'h2, 16'h0003, 10'h010, 1'b0, 1'b0);
      done_test("burst");
      req_go(sdrc_pkg::OP_PRE, 1'b0, 1'b0, 1'b0, 3'h2, 16'h0000, 10'h000);
      req_go(sdrc_pkg::OP_PRE, 1'b0, 1'b0, 1'b1, 3'h0, 16'h0000, 10'h000);
      rd_burst(3'h5, 16'h0000, 10'h040, 1'b0, 1'b1);
      done_test("precharge");
      for (int md = 0; md < 3; md++) begin
         @(posedge clk_sys);
         otf_en <= md == 2;
         mrs_chop <= md == 0;
         @(posedge clk_sys);
         rd_burst(3'h2, 16'h0003, 10'h010, 1'b0, 1'b1);
      end
      done_test("modes");
      for (int h = 0; h < 2; h++) begin
         @(posedge clk_sys);
         hot_temp <= h[0];
         repeat (1600) @(posedge clk_sys);
         r0 = refs;
         repeat (3200) @(posedge clk_sys);
         check(16'((refs - r0) >= 3200 / (h ? 780 : 1560)), 16'h0001);
         check(16'((refs - r0) <= 3200 / (h ? 780 : 1560) + 1), 16'h0001);
      end
      done_test("refresh");
      req_go(sdrc_pkg::OP_SREF, 1'b0, 1'b0, 1'b0, 3'h0, 16'h0000, 10'h000);
      r0 = refs;
      vref_floated <= 1'b1;
      repeat (3000) @(posedge clk_sys);
      check(16'(refs - r0), 16'h0000);
      wr_burst(3'h2, 16'h0003, 10'h080, 1'b0, 1'b1);
      check(16'(last_wait >= 512), 16'h0001);
      vref_floated <= 1'b0;
      rd_burst(3'h2, 16'h0007, 10'h010, 1'b0, 1'b0);
      rd_burst(3'h2, 16'h0003, 10'h080, 1'b1, 1'b1);
      done_test("self_refresh");
      conclude();
   end
endmodule
`default_nettype wire

// >>> tb/sdrc_dram_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdrc_dram_model (
   input wire logic clk_sys,
   input wire logic otf_en,
   input wire logic mrs_chop,
   input wire sdrc_pkg::sdrc_pins_s pins,
   input wire logic dm,
   input wire logic [7:0] dq_out,
   input wire logic dq_oe,
   output logic [7:0] dq_in,
   output logic dqs_in,
   output int viol,
   output int refs
);
   logic [7:0] mem [0:8191];
   logic [7:0] open_b;
   logic [12:0] rd_ptr;
   logic [12:0] wr_ptr;
   logic [3:0] rd_left;
   logic [3:0] rd_n;
   logic [3:0] wr_left;
   logic [3:0] beats;
   int rd_wait;
   int rfc;
   int rp;
   logic cke_q;
   initial begin
      for (int i = 0; i < 8192; i++) mem[i] = 8'(i) ^ 8'h5A;
      open_b = 8'h00;
      rd_left = 4'h0;
      wr_left = 4'h0;
      rd_wait = 0;
      rfc = 0;
      rp = 0;
      viol = 0;
      refs = 0;
      cke_q = 1'b1;
      dq_in = 8'h00;
      dqs_in = 1'b0;
   end
   assign beats = otf_en ? (pins.addr[12] ? 4'h8 : 4'h4) : (mrs_chop ? 4'h4 : 4'h8);
   always @(posedge clk_sys) begin
      cke_q <= pins.cke;
      dqs_in <= ~dqs_in;
      if (rfc > 0) rfc <= rfc - 1;
      if (rp > 0) rp <= rp - 1;
      if (cke_q && !pins.cmd[3]) begin
         if (rfc > 0 && pins.cmd != sdrc_pkg::CMD_NOP) viol <= viol + 1;
         case (pins.cmd)
            sdrc_pkg::CMD_REF: begin
               if (open_b != 8'h00) viol <= viol + 1;
               if (pins.cke) refs <= refs + 1;
               if (pins.cke) rfc <= int'(sdrc_pkg::RFC_CYC);
            end
            sdrc_pkg::CMD_ACT: begin
               if (rp > 0 || open_b[pins.ba]) viol <= viol + 1;
               open_b[pins.ba] <= 1'b1;
            end
            sdrc_pkg::CMD_PRE: begin
               if (pins.addr[10]) open_b <= 8'h00;
               else open_b[pins.ba] <= 1'b0;
               rp <= int'(sdrc_pkg::RP_CYC);
            end
            sdrc_pkg::CMD_RD, sdrc_pkg::CMD_WR: begin
               if (!open_b[pins.ba]) viol <= viol + 1;
               if (pins.addr[10]) open_b[pins.ba] <= 1'b0;
               if (pins.cmd == sdrc_pkg::CMD_RD) begin
                  rd_wait <= int'(sdrc_pkg::RD_LAT) - 2;
                  rd_ptr <= {pins.ba, pins.addr[9:0]};
                  rd_n <= beats;
               end else begin
                  wr_left <= beats;
                  wr_ptr <= {pins.ba, pins.addr[9:0]};
               end
            end
            default: ;
         endcase
      end
      if (rd_wait > 1) rd_wait <= rd_wait - 1;
      else if (rd_wait == 1) begin
         rd_wait <= 0;
         rd_left <= rd_n;
      end
      if (rd_left != 4'h0) begin
         dq_in <= mem[rd_ptr];
         rd_ptr <= rd_ptr + 13'h1;
         rd_left <= rd_left - 4'h1;
      end else dq_in <= ~dq_in;
      if (dq_oe) begin
         if (wr_left == 4'h0) viol <= viol + 1;
         else wr_left <= wr_left - 4'h1;
         if (!dm) mem[wr_ptr] <= dq_out;
         wr_ptr <= wr_ptr + 13'h1;
      end
   end
endmodule
`default_nettype wire
